// file: src/line_control_defines.vh
// constants for the usb suspend and legacy line control block
`ifndef LINE_CONTROL_DEFINES_VH
`define LINE_CONTROL_DEFINES_VH

// clock rate and timing
`define CLK_FREQ_MHZ        100
`define IDLE_TIME_US        3000
`define IDLE_CYCLES         (`IDLE_TIME_US * `CLK_FREQ_MHZ)
`define WAKE_TIME_US        2000
`define WAKE_CYCLES         (`WAKE_TIME_US * `CLK_FREQ_MHZ)

// register indices; byte address is four times the index
`define STATCTL_INDEX       6'h1a
`define EPSTAT_INDEX        6'h1b
`define CLKCTL_INDEX        6'h1c
`define STATCTL_ADDR        {`STATCTL_INDEX, 2'h0}
`define EPSTAT_ADDR         {`EPSTAT_INDEX, 2'h0}
`define CLKCTL_ADDR         {`CLKCTL_INDEX, 2'h0}

// status-control fields
`define STATCTL_SUSPEND     0
`define STATCTL_WAKE        1
`define STATCTL_BUSRST      2
`define STATCTL_RESUME      3
`define STATCTL_DATA_IN     4
`define STATCTL_CLOCK_IN    5
`define STATCTL_DATA_OUT    6
`define STATCTL_CLOCK_OUT   7

// endpoint status fields
`define EPSTAT_FLAG0        0
`define EPSTAT_FLAG1        1
`define EPSTAT_LEGACY_SEL   4
`define EPSTAT_USB_SEL      5
`define EPSTAT_USB_FLAG     7

// clock control fields
`define CLKCTL_USB_CLK_EN   3
`define CLKCTL_SECOND_SUSP  4
`define CLKCTL_CLK_SEL      6
`define CLKCTL_LEGACY_FLAG  7

// reset values
`define KBD_OUT_RESET       1'b1
`define SEL_RESET           1'b0
`define USB_CLK_EN_RESET    1'b0

`endif

// file: src/suspend_detector.v
// bus idle, suspend, resume and suspend exit tracking
`timescale 1ns/1ns
`default_nettype none
`include "line_control_defines.vh"

module suspend_detector #(
	parameter [31:0] IDLE_CYCLES = `IDLE_CYCLES
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        usbMode,
	input  wire        selfDrive,
	input  wire        dPlusIn,
	input  wire        dMinusIn,
	output reg         suspended_reg,
	output reg         resumeFlag_reg,
	output reg         event_reg
);
	localparam [3:0] ST_ACTIVE  = 4'h1;
	localparam [3:0] ST_SUSPEND = 4'h2;
	localparam [3:0] ST_RESUME  = 4'h4;
	localparam [3:0] ST_ENDING  = 4'h8;

	reg  [3:0]  state_reg;
	reg  [31:0] idleCnt_reg;
	// low-speed idle is D- high, D+ low; resume is the opposite K state
	wire        lineIdle  = dMinusIn & ~dPlusIn;
	wire        lineK     = dPlusIn & ~dMinusIn;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg      <= ST_ACTIVE;
			idleCnt_reg    <= 32'h0000_0000;
			suspended_reg  <= 1'b0;
			resumeFlag_reg <= 1'b0;
			event_reg      <= 1'b0;
		end else begin
			event_reg <= 1'b0;
			case (state_reg)
			ST_ACTIVE: begin
				if (!usbMode || !lineIdle) begin
					idleCnt_reg <= 32'h0000_0000;
				end else if (idleCnt_reg >= IDLE_CYCLES) begin
					idleCnt_reg   <= 32'h0000_0000;
					state_reg     <= ST_SUSPEND;
					suspended_reg <= 1'b1;
					event_reg     <= 1'b1;
				end else begin
					idleCnt_reg <= idleCnt_reg + 32'h0000_0001;
				end
			end
			ST_SUSPEND: begin
				if (!usbMode) begin
					state_reg     <= ST_ACTIVE;
					suspended_reg <= 1'b0;
				end else if (lineK && !selfDrive) begin
					state_reg      <= ST_RESUME;
					resumeFlag_reg <= 1'b1;
					event_reg      <= 1'b1;
				end
			end
			ST_RESUME: begin
				// resume drops while suspend still stands
				if (!lineK) begin
					state_reg      <= ST_ENDING;
					resumeFlag_reg <= 1'b0;
				end
			end
			ST_ENDING: begin
				if (lineIdle) begin
					state_reg     <= ST_ACTIVE;
					suspended_reg <= 1'b0;
					event_reg     <= 1'b1;
				end
			end
			default: begin
				state_reg <= ST_ACTIVE;
			end
			endcase
		end
	end
endmodule // suspend_detector

`default_nettype wire

// file: src/line_mux.v
// routes the two data pins to the usb engine or to firmware bits
`timescale 1ns/1ns
`default_nettype none
`include "line_control_defines.vh"

module line_mux (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        legacySel,
	input  wire        usbSel,
	input  wire        wakeDrive,
	input  wire        siePlusOut,
	input  wire        sieMinusOut,
	input  wire        sieOe,
	input  wire        kbdDataOutBit,
	input  wire        kbdClockOutBit,
	output reg         dPlusOut_reg,
	output reg         dPlusOe_reg,
	output reg         dMinusOut_reg,
	output reg         dMinusOe_reg
);
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dPlusOut_reg  <= 1'b0;
			dPlusOe_reg   <= 1'b0;
			dMinusOut_reg <= 1'b0;
			dMinusOe_reg  <= 1'b0;
		end else if (usbSel && !legacySel) begin
			// wake-up pulse drives K over the engine
			dPlusOut_reg  <= wakeDrive ? 1'b1 : siePlusOut;
			dMinusOut_reg <= wakeDrive ? 1'b0 : sieMinusOut;
			dPlusOe_reg   <= wakeDrive | sieOe;
			dMinusOe_reg  <= wakeDrive | sieOe;
		end else if (legacySel && !usbSel) begin
			// open drain: a 1 releases the line, a 0 pulls it low
			dMinusOut_reg <= 1'b0;
			dMinusOe_reg  <= ~kbdDataOutBit;
			dPlusOut_reg  <= 1'b0;
			dPlusOe_reg   <= ~kbdClockOutBit;
		end else begin
			dPlusOut_reg  <= 1'b0;
			dPlusOe_reg   <= 1'b0;
			dMinusOut_reg <= 1'b0;
			dMinusOe_reg  <= 1'b0;
		end
	end
endmodule // line_mux

`default_nettype wire

// file: src/usb_line_control.v
// usb suspend/resume, remote wake and legacy line control with its registers
`timescale 1ns/1ns
`default_nettype none
`include "line_control_defines.vh"

module usb_line_control #(
	parameter [31:0] IDLE_CYCLES = `IDLE_CYCLES,
	parameter [31:0] WAKE_CYCLES = `WAKE_CYCLES
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire [7:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	input  wire [3:0]  byteenable,
	output reg  [31:0] readdata,
	output reg         waitrequest,
	input  wire        dPlusIn,
	input  wire        dMinusIn,
	output wire        dPlusOut,
	output wire        dPlusOe,
	output wire        dMinusOut,
	output wire        dMinusOe,
	input  wire        siePlusOut,
	input  wire        sieMinusOut,
	input  wire        sieOe,
	input  wire        sieBusReset,
	output reg         usbIrq,
	input  wire        irqAck,
	output reg         usbClockEnable,
	output reg         deepSuspendEnable
);
	reg         busResetFlag_reg;
	reg         kbdDataOutBit_reg;
	reg         kbdClockOutBit_reg;
	reg         legacySel_reg;
	reg         usbSel_reg;
	reg  [2:0]  epStore_reg;
	reg  [1:0]  clkStore_reg;
	reg         wakeActive_reg;
	// pins lag the wake flag by one cycle; mask the tail of our own K
	reg         wakeTail_reg;
	reg  [31:0] wakeCnt_reg;
	reg  [7:0]  readByte_next;
	wire        suspended;
	wire        resumeFlag;
	wire        lineEvent;
	wire        legacyMode = legacySel_reg & ~usbSel_reg;
	wire        request    = read | write;
	// a write lands at the edge where waitrequest is seen low
	wire        writeHit   = write & ~waitrequest & byteenable[0];
	wire        wrStatCtl  = writeHit && (address == `STATCTL_ADDR);
	wire        wrEpStat   = writeHit && (address == `EPSTAT_ADDR);
	wire        wrClkCtl   = writeHit && (address == `CLKCTL_ADDR);

	suspend_detector #(
		.IDLE_CYCLES    (IDLE_CYCLES)
	) detector (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.usbMode        (usbSel_reg),
		.selfDrive      (wakeActive_reg | wakeTail_reg),
		.dPlusIn        (dPlusIn),
		.dMinusIn       (dMinusIn),
		.suspended_reg  (suspended),
		.resumeFlag_reg (resumeFlag),
		.event_reg      (lineEvent)
	);

	line_mux pins (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.legacySel      (legacySel_reg),
		.usbSel         (usbSel_reg),
		.wakeDrive      (wakeActive_reg),
		.siePlusOut     (siePlusOut),
		.sieMinusOut    (sieMinusOut),
		.sieOe          (sieOe),
		.kbdDataOutBit  (kbdDataOutBit_reg),
		.kbdClockOutBit (kbdClockOutBit_reg),
		.dPlusOut_reg   (dPlusOut),
		.dPlusOe_reg    (dPlusOe),
		.dMinusOut_reg  (dMinusOut),
		.dMinusOe_reg   (dMinusOe)
	);

	// read value; write-only bits and unmapped addresses read as zero
	always @* begin
		readByte_next = 8'h00;
		if (address == `STATCTL_ADDR) begin
			readByte_next[`STATCTL_SUSPEND]  = suspended;
			readByte_next[`STATCTL_BUSRST]   = busResetFlag_reg;
			readByte_next[`STATCTL_RESUME]   = resumeFlag;
			readByte_next[`STATCTL_DATA_IN]  =
				legacyMode & dMinusIn & kbdDataOutBit_reg;
			readByte_next[`STATCTL_CLOCK_IN] =
				legacyMode & dPlusIn & kbdClockOutBit_reg;
		end else if (address == `EPSTAT_ADDR) begin
			readByte_next[`EPSTAT_FLAG0]      = epStore_reg[0];
			readByte_next[`EPSTAT_FLAG1]      = epStore_reg[1];
			readByte_next[`EPSTAT_LEGACY_SEL] = legacySel_reg;
			readByte_next[`EPSTAT_USB_SEL]    = usbSel_reg;
			readByte_next[`EPSTAT_USB_FLAG]   = epStore_reg[2];
		end else if (address == `CLKCTL_ADDR) begin
			readByte_next[`CLKCTL_USB_CLK_EN]  = usbClockEnable;
			readByte_next[`CLKCTL_SECOND_SUSP] = deepSuspendEnable;
			readByte_next[`CLKCTL_CLK_SEL]     = clkStore_reg[0];
			readByte_next[`CLKCTL_LEGACY_FLAG] = clkStore_reg[1];
		end
	end

	// one wait state: waitrequest drops the cycle after a request shows
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h0000_0000;
		end else begin
			waitrequest <= ~(request & waitrequest);
			if (read && waitrequest) begin
				readdata <= {24'h00_0000, readByte_next};
			end
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busResetFlag_reg   <= 1'b0;
			kbdDataOutBit_reg  <= `KBD_OUT_RESET;
			kbdClockOutBit_reg <= `KBD_OUT_RESET;
			legacySel_reg      <= `SEL_RESET;
			usbSel_reg         <= `SEL_RESET;
			epStore_reg        <= 3'h0;
			clkStore_reg       <= 2'h0;
			usbClockEnable     <= `USB_CLK_EN_RESET;
			deepSuspendEnable  <= 1'b0;
		end else begin
			// hardware set wins over a same-cycle software clear
			if (sieBusReset) begin
				busResetFlag_reg <= 1'b1;
			end else if (wrStatCtl) begin
				busResetFlag_reg <= writedata[`STATCTL_BUSRST];
			end
			if (wrStatCtl) begin
				kbdDataOutBit_reg  <= writedata[`STATCTL_DATA_OUT];
				kbdClockOutBit_reg <= writedata[`STATCTL_CLOCK_OUT];
			end
			if (wrEpStat) begin
				legacySel_reg  <= writedata[`EPSTAT_LEGACY_SEL];
				usbSel_reg     <= writedata[`EPSTAT_USB_SEL];
				epStore_reg[0] <= writedata[`EPSTAT_FLAG0];
				epStore_reg[1] <= writedata[`EPSTAT_FLAG1];
				epStore_reg[2] <= writedata[`EPSTAT_USB_FLAG];
			end
			if (wrClkCtl) begin
				// firmware owns the sequencing around suspend
				usbClockEnable    <= writedata[`CLKCTL_USB_CLK_EN];
				deepSuspendEnable <= writedata[`CLKCTL_SECOND_SUSP];
				clkStore_reg[0]   <= writedata[`CLKCTL_CLK_SEL];
				clkStore_reg[1]   <= writedata[`CLKCTL_LEGACY_FLAG];
			end
		end
	end

	// remote wake-up pulse, only meaningful while pins belong to usb
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wakeActive_reg <= 1'b0;
			wakeCnt_reg    <= 32'h0000_0000;
		end else if (wakeActive_reg) begin
			if (wakeCnt_reg >= WAKE_CYCLES - 32'h0000_0001) begin
				wakeActive_reg <= 1'b0;
				wakeCnt_reg    <= 32'h0000_0000;
			end else begin
				wakeCnt_reg <= wakeCnt_reg + 32'h0000_0001;
			end
		end else if (wrStatCtl && writedata[`STATCTL_WAKE]) begin
			wakeActive_reg <= 1'b1;
			wakeCnt_reg    <= 32'h0000_0000;
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wakeTail_reg <= 1'b0;
		end else begin
			wakeTail_reg <= wakeActive_reg;
		end
	end

	// request held until acknowledged; a new event wins over the ack
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			usbIrq <= 1'b0;
		end else if (lineEvent) begin
			usbIrq <= 1'b1;
		end else if (irqAck) begin
			usbIrq <= 1'b0;
		end
	end
endmodule // usb_line_control

`default_nettype wire

// file: test/usb_line_control_checker.sv
// port assertions for the usb line control block
`timescale 1ns/1ns
`default_nettype none
module usb_line_control_checker (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        dPlusOe,
	input wire logic        dMinusOe,
	input wire logic        usbIrq,
	input wire logic        irqAck
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	reset_vals_a: assert property (disable iff (1'h0) rst |-> waitrequest &&
		!usbIrq && !dPlusOe && !dMinusOe) else $error("reset state");
	wait_one_a: assert property ((read || write) && waitrequest |=>
		!waitrequest) else $error("no answer");
	wait_pulse_a: assert property (!waitrequest |=> waitrequest)
		else $error("long answer");
	wait_idle_a: assert property (!read && !write && waitrequest |=>
		waitrequest) else $error("answer unasked");
	wait_cause_a: assert property ($fell(waitrequest) |->
		$past(read || write)) else $error("answer uncaused");
	upper_zero_a: assert property (read && !waitrequest |->
		readdata[31:8] == 24'h00_0000) else $error("upper data");
	read_hold_a: assert property (!$stable(readdata) |->
		$past(read && waitrequest)) else $error("data moved");
	irq_hold_a: assert property (usbIrq && !irqAck |=> usbIrq)
		else $error("irq dropped");
endmodule // usb_line_control_checker
bind usb_line_control usb_line_control_checker chk (.ref_clk(ref_clk),
	.rst(rst), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest), .dPlusOe(dPlusOe), .dMinusOe(dMinusOe),
	.usbIrq(usbIrq), .irqAck(irqAck));
`default_nettype wire

// file: test/usb_host_model.sv
// far-side host model driving the usb or legacy data lines
`timescale 1ns/1ns
`default_nettype none
module usb_host_model (
	input  wire logic       ref_clk,
	input  wire logic [1:0] lineMode,
	input  wire logic       dPlusOut,
	input  wire logic       dPlusOe,
	input  wire logic       dMinusOut,
	input  wire logic       dMinusOe,
	output var  logic       dPlusIn,
	output var  logic       dMinusIn
);
	logic       tgl = 1'h0, wakeSeen = 1'h0;
	logic [3:0] resumeCnt = 4'h0;
	logic [1:0] host;
	always @(posedge ref_clk) begin
		tgl <= ~tgl;
		wakeSeen <= dPlusOe && dPlusOut && dMinusOe && !dMinusOut;
		// a wake pulse is answered with resume once it ends
		if (wakeSeen && !dPlusOe)
			resumeCnt <= 4'hc;
		else if (resumeCnt != 4'h0)
			resumeCnt <= resumeCnt - 4'h1;
	end
	always @* begin
		case (resumeCnt != 4'h0 ? 2'h1 : lineMode)
			2'h0: host = 2'h1;
			2'h1: host = 2'h2;
			2'h2: host = {tgl, ~tgl};
			default: host = 2'h3; // released, pull-ups win
		endcase
		dPlusIn = dPlusOe ? dPlusOut : host[1];
		dMinusIn = dMinusOe ? dMinusOut : host[0];
	end
endmodule // usb_host_model
`default_nettype wire

// file: test/tb_usb_line_control.sv
// self-checking bench for the usb suspend and legacy line control block
`timescale 1ns/1ns
`default_nettype none
module tb_usb_line_control;
	logic        ref_clk = 1'h0, rst = 1'h0, read = 1'h0, write = 1'h0;
	logic        siePlusOut = 1'h0, sieMinusOut = 1'h0, sieOe = 1'h0;
	logic        sieBusReset = 1'h0, irqAck = 1'h0;
	logic [7:0]  address = 8'h00;
	logic [31:0] writedata = 32'h0000_0000, readdata, rdata;
	logic [3:0]  byteenable = 4'hf;
	logic [1:0]  lineMode = 2'h2;
	logic        waitrequest, dPlusIn, dMinusIn, dPlusOut, dPlusOe, dMinusOut;
	logic        dMinusOe, usbIrq, usbClockEnable, deepSuspendEnable;
	int          fails = 0, comparisons = 0, n, d;
	usb_line_control #(.IDLE_CYCLES(20), .WAKE_CYCLES(10)) dut (.ref_clk,
		.rst, .address, .read, .write, .writedata, .byteenable, .readdata,
		.waitrequest, .dPlusIn, .dMinusIn, .dPlusOut, .dPlusOe, .dMinusOut,
		.dMinusOe, .siePlusOut, .sieMinusOut, .sieOe, .sieBusReset, .usbIrq,
		.irqAck, .usbClockEnable, .deepSuspendEnable);
	usb_host_model host (.ref_clk, .lineMode, .dPlusOut, .dPlusOe,
		.dMinusOut, .dMinusOe, .dPlusIn, .dMinusIn);
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
		@(posedge ref_clk);
		address <= a;
		writedata <= {24'h00_0000, wd};
		read <= !wr;
		write <= wr;
		do @(posedge ref_clk); while (waitrequest !== 1'h0);
		rdata = readdata;
		read <= 1'h0;
		write <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'h0, a, 8'h00);
		chk(rdata, {24'h00_0000, e});
	endtask
	task automatic irq_wait();
		for (n = 0; n < 99 && usbIrq !== 1'h1; n++) @(posedge ref_clk);
		chk(32'(usbIrq), 32'h1);
		irqAck <= 1'h1;
		@(posedge ref_clk);
		irqAck <= 1'h0;
		#1;
	endtask
	task automatic report_and_stop();
		if (fails == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end
	initial begin
		rst <= 1'h1;
		n = $urandom(32'h0000_f7ed);
		repeat (5) @(posedge ref_clk);
		rst <= 1'h0;
		rd(8'h68, 8'h00);
		rd(8'h6c, 8'h00);
		rd(8'h70, 8'h00);
		bus(1'h1, 8'h00, 8'hff);
		rd(8'h00, 8'h00);
		bus(1'h1, 8'h70, 8'h18);
		chk(32'({deepSuspendEnable, usbClockEnable}), 32'h3);
		byteenable <= 4'h0;
		bus(1'h1, 8'h70, 8'h00);
		byteenable <= 4'hf;
		rd(8'h70, 8'h18);
		bus(1'h1, 8'h70, 8'h00);
		chk(32'(usbClockEnable), 32'h0);
		for (n = 0; n < 4; n++) begin
			d = $urandom;
			bus(1'h1, 8'h6c, d[7:0]);
			rd(8'h6c, d[7:0] & 8'hb3);
		end
		bus(1'h1, 8'h6c, 8'h10);
		repeat (2) @(posedge ref_clk);
		chk(32'({dPlusOe, dMinusOe}), 32'h0);
		for (n = 0; n < 8; n++) begin
			d = $urandom;
			lineMode <= d[2] ? 2'h3 : 2'h0;
			bus(1'h1, 8'h68, {d[1:0], 6'h00});
			repeat (3) @(posedge ref_clk);
			rd(8'h68, {2'h0, d[1] & d[2], d[0], 4'h0});
			chk(32'({dPlusOut, dPlusOe, dMinusOut, dMinusOe}),
				32'({1'h0, !d[1], 1'h0, !d[0]}));
		end
		lineMode <= 2'h2;
		bus(1'h1, 8'h6c, 8'h20);
		for (n = 0; n < 6; n++) begin
			d = $urandom;
			{siePlusOut, sieMinusOut, sieOe} <= d[2:0];
			repeat (2) @(posedge ref_clk);
			chk(32'({dPlusOut, dMinusOut, dPlusOe, dMinusOe}),
				32'({d[2:1], d[0], d[0]}));
		end
		{siePlusOut, sieMinusOut, sieOe} <= 3'h0;
		sieBusReset <= 1'h1;
		@(posedge ref_clk);
		sieBusReset <= 1'h0;
		rd(8'h68, 8'h04);
		bus(1'h1, 8'h68, 8'hc0);
		rd(8'h68, 8'h00);
		lineMode <= 2'h0;
		irq_wait();
		rd(8'h68, 8'h01);
		lineMode <= 2'h1;
		irq_wait();
		rd(8'h68, 8'h09);
		lineMode <= 2'h0;
		irq_wait();
		rd(8'h68, 8'h00);
		irq_wait();
		bus(1'h1, 8'h68, 8'hc2);
		for (n = 0; n < 9 && !(dPlusOe && dPlusOut); n++) @(posedge ref_clk);
		chk(32'({dPlusOut, dPlusOe, dMinusOut, dMinusOe}), 32'hd);
		irq_wait();
		irq_wait();
		rd(8'h68, 8'h00);
		bus(1'h1, 8'h70, 8'h08);
		chk(32'({deepSuspendEnable, usbClockEnable}), 32'h1);
		report_and_stop();
	end
endmodule // tb_usb_line_control
`default_nettype wire
